// [rtl/asc_map.svh]
// register indices, field positions, reset values and timing counts
// assumes: included by bare name from any file of the converter block
`ifndef ASC_MAP_SVH
`define ASC_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define ASC_IDX_CTRL 10'h034
`define ASC_IDX_HIGH 10'h035
`define ASC_IDX_LOW 10'h036
`define ASC_IDX_IRQ_STS 10'h037
`define ASC_IDX_IRQ_MSK 10'h038

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ASC_CS_DONE 7
`define ASC_CS_SPEED 6
`define ASC_CS_ON 5
`define ASC_CS_CH_HI 2
`define ASC_CS_CH_LO 0
`define ASC_RL_SLOW 3
`define ASC_IRQ_DONE 0
`define ASC_IRQ_OVR 1

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define ASC_RST_BYTE 8'h00
`define ASC_RST_CH 3'h0
`define ASC_RST_RES 10'h000
`define ASC_RST_IRQ 2'h0
`define ASC_RST_WORD 32'h0000_0000
`define ASC_SAR_FIRST 10'h200
`define ASC_MSB_IDX 4'h9
`define ASC_LSB_IDX 4'h0
`define ASC_CNT_ZERO 4'h0
`define ASC_CNT_ONE 4'h1

// ----------------------------------------------------------------------
// timing counts, in converter clock ticks
// ----------------------------------------------------------------------
`define ASC_SAMPLE_TICKS 4'h8
`define ASC_SETTLE_TICKS 4'h6

// ----------------------------------------------------------------------
// converter clock divider
// ----------------------------------------------------------------------
`define ASC_DIV_ZERO 2'h0
`define ASC_DIV_ONE 2'h1
`define ASC_DIV4_LAST 2'h3

`endif

// [rtl/asc_pkg.sv]
// types shared by the converter sequencing block
// assumes: compiled before every other file of the block
package asc_pkg;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ASC_OFF = 2'b00,
        ASC_SAMPLE = 2'b01,
        ASC_TRIAL = 2'b10
    } asc_state_t;

endpackage

// [rtl/asc_tick_if.sv]
// converter clock tick link between the sequencer and its divider
// assumes: both ends on pclk
`timescale 1ns/1ps
`default_nettype none

interface asc_tick_if;
    logic run;
    logic slow;
    logic speed;
    logic tick;

    modport div (input run, input slow, input speed, output tick);
    modport ctl (output run, output slow, output speed, input tick);
endinterface

`default_nettype wire

// [rtl/asc_clk_div.sv]
// converter clock divider: one tick per converter clock period
// assumes: pclk is the cpu clock; settings come from the sequencer
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"

module asc_clk_div (
    input wire logic pclk,
    input wire logic presetn,
    asc_tick_if.div tk
);
    logic [1:0] div_r;

    // ------------------------------------------------------------------
    // prescale counter
    // ------------------------------------------------------------------
    // held at zero while off so the first period after enable is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= `ASC_DIV_ZERO;
        end else if (!tk.run) begin
            div_r <= `ASC_DIV_ZERO;
        end else begin
            div_r <= div_r + `ASC_DIV_ONE;
        end
    end

    // slow wins over speed: cpu/4, else cpu/1 or cpu/2
    always_comb begin
        if (tk.slow) begin
            tk.tick = tk.run && (div_r == `ASC_DIV4_LAST);
        end else if (tk.speed) begin
            tk.tick = tk.run;
        end else begin
            tk.tick = tk.run && div_r[0];
        end
    end
endmodule

`default_nettype wire

// [rtl/asc_seq_ctrl.sv]
// converter control, successive approximation sequencer and result regs
// assumes: apb master on pclk; analog core drives cmp_in asynchronously
// and presents the trial code on ana_dac to its comparator
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"

// Notes on behaviour
// - input above upper reference reads full scale, 3FF, no overflow flag
// - input below lower reference reads zero in both result registers
// - three-bit channel select picks inputs zero to six in binary order
// - setting converter on starts continuous back-to-back conversions
// - clearing converter on stops conversions and powers the core down
// - each finished conversion loads the result and sets done flag
// - reading result high or writing control clears done; low read doesn't
// - done flag is read-only; other control bits read and write
// - channel change aborts conversion, clears done, restarts new channel
// - slow gives cpu/4; else speed gives cpu/1 or cpu/2
// - result high holds bits nine to two; low holds bits one, zero
// - reserved bits of result low always read zero
// - cpu wait mode leaves the converter running
module asc_seq_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic lp_halt,
    input wire logic cmp_in,
    output logic ana_power_on,
    output logic [2:0] ana_channel,
    output logic ana_sample,
    output logic [9:0] ana_dac
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    asc_pkg::asc_state_t state_r;
    logic [3:0] cnt_r;
    logic [3:0] bit_r;
    logic [9:0] sar_r;
    logic [9:0] sar_dec;
    logic [9:0] result_r;
    logic done_r;
    logic speed_r;
    logic on_r;
    logic [2:0] ch_r;
    logic slow_r;
    logic [1:0] irq_sts_r;
    logic [1:0] irq_msk_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic irq_r;
    logic power_r;
    logic sample_r;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_s3;
    logic cmp_q;
    logic run;
    logic setup;
    logic acc;
    logic wr_lane;
    logic sel_ctrl;
    logic sel_high;
    logic sel_low;
    logic sel_sts;
    logic sel_msk;
    logic mapped;
    logic wr_ctrl;
    logic rd_high;
    logic chan_change;
    logic last_tick;
    logic conv_end;
    logic [31:0] rdata_nxt;
    logic [1:0] irq_evt;

    asc_tick_if tk ();

    // ------------------------------------------------------------------
    // converter clock
    // ------------------------------------------------------------------
    // halt stops the converter whatever software left in the on bit;
    // there is no wait-mode input because wait must not touch it
    assign run = on_r && !lp_halt;
    assign tk.run = run;
    assign tk.slow = slow_r;
    assign tk.speed = speed_r;

    asc_clk_div u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tk(tk)
    );

    // ------------------------------------------------------------------
    // comparator synchroniser
    // ------------------------------------------------------------------
    // three stages; a level counts only once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_s3 <= 1'b0;
        end else begin
            cmp_s1 <= cmp_in;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q <= 1'b0;
        end else if (cmp_s2 == cmp_s3) begin
            cmp_q <= cmp_s3;
        end
    end

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    assign setup = psel && !penable;
    assign acc = psel && penable && pready_r;
    assign wr_lane = acc && pwrite && pstrb[0];
    assign sel_ctrl = (paddr[11:2] == `ASC_IDX_CTRL);
    assign sel_high = (paddr[11:2] == `ASC_IDX_HIGH);
    assign sel_low = (paddr[11:2] == `ASC_IDX_LOW);
    assign sel_sts = (paddr[11:2] == `ASC_IDX_IRQ_STS);
    assign sel_msk = (paddr[11:2] == `ASC_IDX_IRQ_MSK);
    assign mapped = sel_ctrl || sel_high || sel_low || sel_sts || sel_msk;
    assign wr_ctrl = wr_lane && sel_ctrl;
    assign rd_high = acc && !pwrite && sel_high;
    // only a real change of channel while running aborts the conversion
    assign chan_change = wr_ctrl && run
        && (pwdata[`ASC_CS_CH_HI:`ASC_CS_CH_LO] != ch_r);

    // read mux; reserved bits are left at zero
    always_comb begin
        rdata_nxt = `ASC_RST_WORD;
        if (sel_ctrl) begin
            rdata_nxt[`ASC_CS_DONE] = done_r;
            rdata_nxt[`ASC_CS_SPEED] = speed_r;
            rdata_nxt[`ASC_CS_ON] = on_r;
            rdata_nxt[`ASC_CS_CH_HI:`ASC_CS_CH_LO] = ch_r;
        end else if (sel_high) begin
            rdata_nxt[7:0] = result_r[9:2];
        end else if (sel_low) begin
            rdata_nxt[`ASC_RL_SLOW] = slow_r;
            rdata_nxt[1:0] = result_r[1:0];
        end else if (sel_sts) begin
            rdata_nxt[1:0] = irq_sts_r;
        end else if (sel_msk) begin
            rdata_nxt[1:0] = irq_msk_r;
        end
    end

    // ------------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------------
    // read data is caught in the setup cycle so prdata leaves a flop;
    // costs nothing since pready is high in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= `ASC_RST_WORD;
        end else begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            if (setup) begin
                prdata_r <= rdata_nxt;
            end
        end
    end

    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    // ------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------
    // bits four and three of control are not stored; software keeps them 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_r <= 1'b0;
            on_r <= 1'b0;
            ch_r <= `ASC_RST_CH;
        end else if (wr_ctrl) begin
            speed_r <= pwdata[`ASC_CS_SPEED];
            on_r <= pwdata[`ASC_CS_ON];
            ch_r <= pwdata[`ASC_CS_CH_HI:`ASC_CS_CH_LO];
        end
    end

    // slow select lives in the result-low register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            slow_r <= 1'b0;
        end else if (wr_lane && sel_low) begin
            slow_r <= pwdata[`ASC_RL_SLOW];
        end
    end

    // ------------------------------------------------------------------
    // done flag
    // ------------------------------------------------------------------
    // completion wins over a clear in the same cycle, so no result is lost;
    // reading result low never touches it, which keeps the 10-bit sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_r <= 1'b0;
        end else if (conv_end) begin
            done_r <= 1'b1;
        end else if (rd_high || wr_ctrl) begin
            done_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // successive approximation sequencer
    // ------------------------------------------------------------------
    assign last_tick = (state_r == asc_pkg::ASC_TRIAL) && tk.tick
        && (cnt_r == `ASC_SETTLE_TICKS - `ASC_CNT_ONE);
    assign conv_end = last_tick && (bit_r == `ASC_LSB_IDX);

    // keep the trial bit only when the comparator says input is higher;
    // an input above range keeps every bit, below range keeps none
    always_comb begin
        sar_dec = sar_r;
        if (!cmp_q) begin
            sar_dec[bit_r] = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= asc_pkg::ASC_OFF;
            cnt_r <= `ASC_CNT_ZERO;
            bit_r <= `ASC_MSB_IDX;
            sar_r <= `ASC_RST_RES;
        end else if (!run) begin
            state_r <= asc_pkg::ASC_OFF;
            cnt_r <= `ASC_CNT_ZERO;
        end else if (chan_change) begin
            state_r <= asc_pkg::ASC_SAMPLE;
            cnt_r <= `ASC_CNT_ZERO;
        end else begin
            unique case (state_r)
                asc_pkg::ASC_OFF: begin
                    state_r <= asc_pkg::ASC_SAMPLE;
                    cnt_r <= `ASC_CNT_ZERO;
                end
                asc_pkg::ASC_SAMPLE: begin
                    if (tk.tick) begin
                        if (cnt_r == `ASC_SAMPLE_TICKS - `ASC_CNT_ONE) begin
                            state_r <= asc_pkg::ASC_TRIAL;
                            cnt_r <= `ASC_CNT_ZERO;
                            bit_r <= `ASC_MSB_IDX;
                            sar_r <= `ASC_SAR_FIRST;
                        end else begin
                            cnt_r <= cnt_r + `ASC_CNT_ONE;
                        end
                    end
                end
                asc_pkg::ASC_TRIAL: begin
                    if (last_tick) begin
                        cnt_r <= `ASC_CNT_ZERO;
                        sar_r <= sar_dec;
                        if (bit_r == `ASC_LSB_IDX) begin
                            state_r <= asc_pkg::ASC_SAMPLE;
                        end else begin
                            sar_r[bit_r - `ASC_CNT_ONE] <= 1'b1;
                            bit_r <= bit_r - `ASC_CNT_ONE;
                        end
                    end else if (tk.tick) begin
                        cnt_r <= cnt_r + `ASC_CNT_ONE;
                    end
                end
                default: begin
                    state_r <= asc_pkg::ASC_OFF;
                    cnt_r <= `ASC_CNT_ZERO;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // result register
    // ------------------------------------------------------------------
    // one 10-bit flop so both halves always come from the same conversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_r <= `ASC_RST_RES;
        end else if (conv_end) begin
            result_r <= sar_dec;
        end
    end

    // ------------------------------------------------------------------
    // analog core controls
    // ------------------------------------------------------------------
    // sample stays up through an abort from sampling, so no false dip
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_r <= 1'b0;
            sample_r <= 1'b0;
        end else begin
            power_r <= run;
            sample_r <= run
                && (state_r == asc_pkg::ASC_SAMPLE);
        end
    end

    assign ana_power_on = power_r;
    assign ana_sample = sample_r;
    assign ana_channel = ch_r;
    assign ana_dac = sar_r;

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    // overrun marks a result landing while the previous one was unread
    assign irq_evt = {conv_end && done_r, conv_end};

    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_sts_r <= `ASC_RST_IRQ;
        end else if (wr_lane && sel_sts) begin
            irq_sts_r <= (irq_sts_r & ~pwdata[1:0]) | irq_evt;
        end else begin
            irq_sts_r <= irq_sts_r | irq_evt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_msk_r <= `ASC_RST_IRQ;
        end else if (wr_lane && sel_msk) begin
            irq_msk_r <= pwdata[1:0];
        end
    end

    // registered, so irq trails the status bit by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(irq_sts_r & irq_msk_r);
        end
    end

    assign irq = irq_r;
endmodule

`default_nettype wire

// [verif/asc_ana_model.sv]
// analog core stand-in: sample-and-hold plus comparator
// assumes: one level per channel from the bench; pclk is the cpu clock
`timescale 1ns/1ps
`default_nettype none

module asc_ana_model (
    input wire logic pclk,
    input wire logic [6:0][10:0] lvl,
    input wire logic ana_power_on,
    input wire logic [2:0] ana_channel,
    input wire logic ana_sample,
    input wire logic [9:0] ana_dac,
    output logic cmp_in
);
    logic [10:0] held_r = 11'h000;
    logic tog_r = 1'b0;

    // track the chosen input while sampling; toggle keeps idle output noisy
    always @(posedge pclk) begin
        tog_r <= ~tog_r;
        if (ana_sample) begin
            held_r <= lvl[ana_channel];
        end
    end

    // levels past either reference saturate every trial one way
    assign cmp_in = ana_power_on ? (held_r >= {1'b0, ana_dac}) : tog_r;
endmodule

`default_nettype wire

// [verif/asc_seq_checker.sv]
// port-level checks of the converter sequencing block
// assumes: bound to asc_seq_ctrl; single pclk domain
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"

module asc_seq_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic lp_halt,
    input wire logic ana_power_on,
    input wire logic [2:0] ana_channel,
    input wire logic ana_sample,
    input wire logic [9:0] ana_dac
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    logic mapped;
    assign mapped = paddr[11:2] >= `ASC_IDX_CTRL
        && paddr[11:2] <= `ASC_IDX_IRQ_MSK;
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(logic [9:0] idx);
        pready && !pwrite && paddr[11:2] == idx;
    endsequence

    // -------------------------------------------------------------
    // bus and converter relations
    // -------------------------------------------------------------
    ready_pulse_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("ready not a single pulse after setup");
    err_unmapped_a: assert property (setup_s ##0 !mapped |=> pslverr)
        else $error("unmapped access without error");
    err_mapped_a: assert property (setup_s ##0 mapped |=> !pslverr)
        else $error("error on a mapped register");
    rdata_width_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data above the byte not zero");
    low_reserved_a: assert property (rd_s(`ASC_IDX_LOW) |->
        prdata[7:4] == 4'h0 && !prdata[2])
        else $error("reserved result low bits not zero");
    ctrl_reserved_a: assert property (rd_s(`ASC_IDX_CTRL) |->
        prdata[4:3] == 2'h0)
        else $error("reserved control bits not zero");
    halt_power_a: assert property (lp_halt |=> !ana_power_on)
        else $error("converter powered in halt");
    off_sample_a: assert property (!ana_power_on |=> !ana_sample)
        else $error("sampling while converter off");
    first_trial_a: assert property ($fell(ana_sample) && ana_power_on
        |-> ##[0:4] ana_dac == `ASC_SAR_FIRST)
        else $error("first trial is not the top bit");
    // a bus write may abort the conversion, so it suspends the check
    trial_hold_a: assert property (@(posedge pclk)
        disable iff (!presetn || (psel && pwrite))
        $changed(ana_dac) && !ana_sample && ana_power_on
        |=> $stable(ana_dac)[*3])
        else $error("trial code held too briefly");
    channel_range_a: assert property (ana_power_on |-> ana_channel <= 3'h6)
        else $error("channel outside zero to six");
endmodule

bind asc_seq_ctrl asc_seq_checker chk_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lp_halt(lp_halt),
    .ana_power_on(ana_power_on), .ana_channel(ana_channel),
    .ana_sample(ana_sample), .ana_dac(ana_dac));

`default_nettype wire

// [verif/tb.sv]
// self-checking bench: apb register tests against the analog model
// assumes: design files, map header and model compiled before this one
`timescale 1ns/1ps
`default_nettype none
`include "asc_map.svh"

module tb;
    localparam logic [9:0] i_cs = `ASC_IDX_CTRL;
    localparam logic [9:0] i_hi = `ASC_IDX_HIGH;
    localparam logic [9:0] i_lo = `ASC_IDX_LOW;
    localparam logic [9:0] i_st = `ASC_IDX_IRQ_STS;
    localparam logic [9:0] i_mk = `ASC_IDX_IRQ_MSK;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic lp_halt = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rdv;
    logic pready, pslverr, irq, cmp_in, ana_power_on, ana_sample, erv;
    logic [2:0] ana_channel;
    logic [9:0] ana_dac, r;
    // channel 0 above the top reference, channel 1 at zero
    logic [6:0][10:0] lvl = {11'h200, 11'h3FE, 11'h001, 11'h2AA, 11'h155,
        11'h000, 11'h7FF};
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0, d, dv;

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;

    asc_seq_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .lp_halt(lp_halt), .cmp_in(cmp_in),
        .ana_power_on(ana_power_on), .ana_channel(ana_channel),
        .ana_sample(ana_sample), .ana_dac(ana_dac));
    asc_ana_model ana_u (.pclk(pclk), .lvl(lvl), .ana_power_on(ana_power_on),
        .ana_channel(ana_channel), .ana_sample(ana_sample),
        .ana_dac(ana_dac), .cmp_in(cmp_in));

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    function automatic logic [9:0] res(input logic [10:0] l);
        return (l > 11'h3FF) ? 10'h3FF : l[9:0];
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [9:0] a,
        input logic [7:0] v);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'h0};
        pwdata <= {24'h0, v};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rc(input logic [9:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rdv, {24'h0, e});
    endtask

    // poll the done flag; d is cycles since t0
    task automatic pd();
        int n;
        n = 0;
        do begin
            xfer(1'b0, i_cs, 8'h00);
            n++;
        end while (rdv[7] !== 1'b1 && n < 500);
        if (n >= 500) failures++;
        d = cyc - t0;
    endtask

    task automatic print_verdict();
        $display("checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // -------------------------------------------------------------
    // tests
    // -------------------------------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rc(i_cs + 10'(i), 8'h00);
        end
        xfer(1'b0, 10'h040, 8'h00);
        chk({rdv[31:1], erv}, 32'h1);
        $display("test reset finished");
        // every channel, results split high/low, low read keeps done
        for (int c = 0; c < 7; c++) begin
            r = res(lvl[c]);
            xfer(1'b1, i_cs, 8'h60 | 8'(c));
            pd();
            chk({29'h0, ana_channel}, 32'(c));
            rc(i_lo, {6'h0, r[1:0]});
            rc(i_cs, 8'hE0 | 8'(c));
            rc(i_hi, r[9:2]);
            rc(i_cs, 8'h60 | 8'(c));
            pd();
            rc(i_hi, r[9:2]);
        end
        pd();
        xfer(1'b1, i_cs, 8'hE6);
        rc(i_cs, 8'h66);
        pstrb <= 4'h0;
        xfer(1'b1, i_cs, 8'h00);
        pstrb <= 4'hF;
        xfer(1'b1, i_hi, 8'h00);
        rc(i_hi, r[9:2]);
        rc(i_cs, 8'h66);
        $display("test access finished");
        // clock rates; slow overrides speed
        r = res(lvl[2]);
        for (int k = 0; k < 4; k++) begin
            dv = k[1] ? 4 : (k[0] ? 1 : 2);
            xfer(1'b1, i_cs, 8'h00);
            xfer(1'b1, i_lo, {4'h0, k[1], 3'h0});
            t0 = cyc;
            xfer(1'b1, i_cs, {1'b0, k[0], 6'h22});
            pd();
            chk(32'(d >= 68 * dv && d <= 68 * dv + 12), 32'h1);
            rc(i_lo, {4'h0, k[1], 1'b0, r[1:0]});
        end
        // channel change mid conversion restarts the count
        xfer(1'b1, i_cs, 8'h23);
        repeat (100) @(posedge pclk);
        t0 = cyc;
        xfer(1'b1, i_cs, 8'h24);
        rc(i_cs, 8'h24);
        pd();
        chk(32'(d >= 272), 32'h1);
        r = res(lvl[4]);
        rc(i_hi, r[9:2]);
        $display("test rates finished");
        // off bit, then halt pin
        xfer(1'b1, i_cs, 8'h04);
        repeat (400) @(posedge pclk);
        rc(i_cs, 8'h04);
        chk({31'h0, ana_power_on}, 32'h0);
        xfer(1'b1, i_cs, 8'h24);
        lp_halt <= 1'b1;
        repeat (400) @(posedge pclk);
        rc(i_cs, 8'h24);
        lp_halt <= 1'b0;
        pd();
        $display("test power finished");
        // done interrupt, mask, overrun, clear
        xfer(1'b1, i_lo, 8'h00);
        xfer(1'b1, i_cs, 8'h60);
        xfer(1'b1, i_st, 8'h03);
        xfer(1'b1, i_mk, 8'h01);
        pd();
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        xfer(1'b1, i_mk, 8'h00);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        repeat (150) @(posedge pclk);
        rc(i_st, 8'h03);
        xfer(1'b1, i_cs, 8'h00);
        xfer(1'b1, i_st, 8'h03);
        rc(i_st, 8'h00);
        $display("test interrupt finished");
        print_verdict();
    end

    // hang guard, well past the expected run length
    initial begin
        repeat (30000) @(posedge pclk);
        failures++;
        print_verdict();
    end
endmodule

`default_nettype wire
